// >>> dv/rio_link_top_bench.sv
// Self-checking bench of the link unit over AXI4-Lite and the serial line.
// Assumes the terminal model and shortened bit, cycle and timeout counts.
`timescale 1ns/10ps
`default_nettype none
`include "rio_defines.svh"
module rio_link_top_bench;
  localparam int unsigned BIT_CYC     = 8;
  localparam int unsigned CYCLE_CYC   = 400;
  localparam int unsigned TIMEOUT_CYC = 600;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0]  r;
  logic        rx_line, tx_line, fault, irq, got_bad;
  logic [15:0] got_word;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  time         t_fall = 0;
  time         t_rise = 0;
  int          gap = 0;

  always #12.5 ref_clk = ~ref_clk;

  rio_link_top #(.BIT_CYC(BIT_CYC), .CYCLE_CYC(CYCLE_CYC),
                 .TIMEOUT_CYC(TIMEOUT_CYC)) u_rio_link_top (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .serial_line_terminal_rx_in(rx_line),
    .serial_line_terminal_tx_out(tx_line), .fault_out(fault),
    .irq_out(irq));

  rio_term_model #(.BIT_CYC(BIT_CYC)) u_rio_term_model (
    .ref_clk_in(ref_clk), .line_in(tx_line), .line_out(rx_line),
    .got_word_out(got_word), .got_bad_out(got_bad));

  // ==========================================================================
  // Cycle count, hang guard and frame spacing on the output line
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  // Frame starts only: a fall after a high run longer than a frame
  always @(posedge tx_line) t_rise = $time;

  always @(negedge tx_line) begin
    if ($time - t_rise > `RIO_TX_BITS * BIT_CYC * 25) begin
      gap = int'(($time - t_fall) / 25);
      t_fall = $time;
    end
  end

  // ==========================================================================
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic da, dw, ha, hw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge ref_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      da = da | ha;
      dw = dw | hw;
    end
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp, input logic [1:0] er);
    rd(a);
    check(what, d, exp);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic frame(input logic [15:0] v, input logic bad);
    u_rio_term_model.send_frame(v, bad);
    repeat (4) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk("ctrl", `RIO_ADDR_CTRL, 32'h2, 2'h0); // RESET
    // Transmitter is on from reset, so a frame start is already logged
    rd_chk("stat", `RIO_ADDR_STAT, 32'h4, 2'h0); // RESET
    check("irq", {31'h0, irq}, 32'h0); // RESET
    rd_chk("unmapped", 8'h18, 32'h0, `RIO_RESP_SLVERR);
    wr(8'h18, 32'h1, `RIO_RESP_SLVERR);
    wr(`RIO_ADDR_CTRL, 32'h0, 2'h0);
    frame(16'ha5c3, 1'b0);
    rd_chk("in16", `RIO_ADDR_IN, 32'ha5c3, 2'h0);
    wr(`RIO_ADDR_IN, 32'hffff, 2'h0);
    rd_chk("in_ro", `RIO_ADDR_IN, 32'ha5c3, 2'h0);
    wr(`RIO_ADDR_CTRL, 32'h1, 2'h0);
    frame(16'hffff, 1'b0);
    rd_chk("in15", `RIO_ADDR_IN, 32'h7fff, 2'h0);
    wr(`RIO_ADDR_STAT, 32'h7, 2'h0);
    wr(`RIO_ADDR_MASK, 32'h2, 2'h0);
    frame(16'h1111, 1'b1);
    check("fault", {31'h0, fault}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk("in_err", `RIO_ADDR_IN, 32'hffff, 2'h0);
    wr(`RIO_ADDR_STAT, 32'h2, 2'h0);
    repeat (2) @(posedge ref_clk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    frame(16'h0f0f, 1'b0);
    check("fault_off", {31'h0, fault}, 32'h0);
    check("irq_mask", {31'h0, irq}, 32'h0);
    rd_chk("in_new", `RIO_ADDR_IN, 32'h0f0f, 2'h0);
    u_rio_term_model.set_power(1'b0);
    repeat (TIMEOUT_CYC + 40) @(posedge ref_clk);
    check("fault_lost", {31'h0, fault}, 32'h1);
    rd_chk("link", `RIO_ADDR_LINK, 32'h1, 2'h0);
    u_rio_term_model.set_power(1'b1);
    wr(`RIO_ADDR_CTRL, 32'h0, 2'h0);
    frame(16'h1234, 1'b0);
    rd_chk("in_zero", `RIO_ADDR_IN, 32'h0, 2'h0);
    check("fault_back", {31'h0, fault}, 32'h0);
    wr(`RIO_ADDR_OUT, 32'h5a3c, 2'h0);
    rd_chk("out", `RIO_ADDR_OUT, 32'h5a3c, 2'h0);
    wr(`RIO_ADDR_CTRL, 32'h2, 2'h0);
    for (int n = 0; n < 2000 && got_word !== 16'h5a3c; n++)
      @(posedge ref_clk);
    check("out_word", {16'h0, got_word}, 32'h5a3c);
    check("out_bad", {31'h0, got_bad}, 32'h0);
    repeat (2 * CYCLE_CYC) @(posedge ref_clk);
    check("gap", gap, CYCLE_CYC);
    rd(`RIO_ADDR_STAT);
    check("stat_tx", d & 32'h4, 32'h4);
    complete_run();
  end
endmodule // rio_link_top_bench
`default_nettype wire

// >>> dv/rio_term_model.sv
// Model of the remote input and output terminals on the two-wire line.
// Assumes the unit's frame: start, 16 data LSB first, even parity, stop.
`timescale 1ns/10ps
`default_nettype none
module rio_term_model #(
  parameter int unsigned BIT_CYC = 8
) (
  input  wire logic   ref_clk_in,
  input  wire logic   line_in,
  output logic        line_out,
  output logic [15:0] got_word_out,
  output logic        got_bad_out
);
  logic fresh_q;
  logic [15:0] w;
  logic        ok;

  initial begin
    line_out = 1'b1;
    got_word_out = 16'h0000;
    got_bad_out = 1'b0;
    fresh_q = 1'b0;
  end

  // ==========================================================================
  // Input terminal: line idles high, also while unpowered (pull-up)
  task automatic set_power(input logic on);
    fresh_q = on;
  endtask

  task automatic send_frame(input logic [15:0] d, input logic bad);
    logic [18:0] f;
    if (fresh_q) d = 16'h0000;
    fresh_q = 1'b0;
    f = {1'b1, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 19; i++) begin
      @(posedge ref_clk_in);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk_in);
    end
  endtask

  // ==========================================================================
  // Output terminal: mid-bit sampling, checks its own frames
  always begin : rx_proc
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge ref_clk_in);
    ok = (line_in === 1'b0);
    for (int i = 0; i < 16; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk_in);
      w[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge ref_clk_in);
    ok = ok && ((^w) === line_in);
    repeat (BIT_CYC) @(posedge ref_clk_in);
    ok = ok && (line_in === 1'b1);
    if (ok) got_word_out = w;
    got_bad_out = !ok;
  end
endmodule // rio_term_model
`default_nettype wire

// >>> rtl/rio_defines.svh
// Constants of the two-wire remote I/O link: offsets, fields, resets, times.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef RIO_DEFINES_SVH
`define RIO_DEFINES_SVH

// ==========================================================================
// Clock and link timing
`define RIO_CLK_HZ         40000000
`define RIO_CLK_PER_US     (`RIO_CLK_HZ / 1000000)
`define RIO_BIT_TIME_US    1000
`define RIO_CYCLE_TIME_US  19200
`define RIO_TIMEOUT_US     31000
`define RIO_BIT_CYC        (`RIO_BIT_TIME_US * `RIO_CLK_PER_US)
`define RIO_CYCLE_CYC      (`RIO_CYCLE_TIME_US * `RIO_CLK_PER_US)
`define RIO_TIMEOUT_CYC    (`RIO_TIMEOUT_US * `RIO_CLK_PER_US)

// ==========================================================================
// Frame layout: start, 16 data LSB first, even parity, stop
`define RIO_DATA_BITS      16
`define RIO_RX_BITS        17
`define RIO_TX_BITS        19

// ==========================================================================
// Register byte offsets
`define RIO_ADDR_IN        8'h00
`define RIO_ADDR_OUT       8'h04
`define RIO_ADDR_CTRL      8'h08
`define RIO_ADDR_STAT      8'h0c
`define RIO_ADDR_MASK      8'h10
`define RIO_ADDR_LINK      8'h14

// ==========================================================================
// Fields and reset values
`define RIO_CTRL_MODE15    0
`define RIO_CTRL_TXEN      1
`define RIO_CTRL_RST       2'h2
`define RIO_EV_RX          0
`define RIO_EV_ERR         1
`define RIO_EV_TX          2
`define RIO_EV_RST         3'h0
`define RIO_ERR_BIT        15
`define RIO_RESP_OKAY      2'h0
`define RIO_RESP_SLVERR    2'h2

`endif

// >>> rtl/rio_link_top.sv
// Two-wire remote I/O link unit: 16 input points and 16 output points.
// Assumes an AXI4-Lite master on ref_clk_in and remote terminals on the pins.
`timescale 1ns/10ps
`default_nettype none
`include "rio_defines.svh"
module rio_link_top #(
  parameter int unsigned BIT_CYC     = `RIO_BIT_CYC,
  parameter int unsigned CYCLE_CYC   = `RIO_CYCLE_CYC,
  parameter int unsigned TIMEOUT_CYC = `RIO_TIMEOUT_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        serial_line_terminal_rx_in,
  output logic             serial_line_terminal_tx_out,
  output logic             fault_out,
  output logic             irq_out
);
  import rio_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `RIO_ADDR_IN) || (a == `RIO_ADDR_OUT) ||
             (a == `RIO_ADDR_CTRL) || (a == `RIO_ADDR_STAT) ||
             (a == `RIO_ADDR_MASK) || (a == `RIO_ADDR_LINK);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  // ========================================================================
  // Line synchroniser and receiver
  logic sync1_q, sync2_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= serial_line_terminal_rx_in;
      sync2_q <= sync1_q;
    end
  end

  rio_rx_if rx_c ();
  rio_rx_frame #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .line_in    (sync2_q),
    .rx         (rx_c.rx)
  );

  // ========================================================================
  // Received data, error and frame timeout
  rio_word_t   data_q, data_d;
  logic        err_q, err_d;
  logic [31:0] tmo_q, tmo_d;
  logic        tmo_hit;

  always_comb begin
    data_d  = data_q;
    err_d   = err_q;
    tmo_hit = (tmo_q >= 32'(TIMEOUT_CYC - 1));
    tmo_d   = tmo_hit ? 32'h0 : tmo_q + 32'h1;
    if (rx_c.done) begin
      tmo_d = 32'h0;
      if (rx_c.ok) begin
        data_d = rx_c.data;
        err_d  = 1'b0;
      end else begin
        err_d = 1'b1;
      end
    end else if (tmo_hit) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_q <= 16'h0;
      err_q  <= 1'b0;
      tmo_q  <= 32'h0;
    end else begin
      data_q <= data_d;
      err_q  <= err_d;
      tmo_q  <= tmo_d;
    end
  end

  // ========================================================================
  // Registers and interrupt
  logic [1:0]  ctrl_q, ctrl_d;
  rio_word_t   out_q, out_d;
  logic [2:0]  stat_q, stat_d, mask_q, mask_d, ev;
  logic        irq_q, irq_d, fault_q;
  logic        tx_load;
  rio_word_t   in_word;

  // bit 15 is input 15 or the error bit
  assign in_word = {ctrl_q[`RIO_CTRL_MODE15] ? err_q :
                                               data_q[15],
                    data_q[14:0]};

  logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic        arr_q, arr_d, rv_q, rv_d;
  logic        do_wr;
  logic [31:0] wv;

  assign ev[`RIO_EV_RX]  = rx_c.done && rx_c.ok;
  assign ev[`RIO_EV_ERR] = err_d && !err_q;
  assign ev[`RIO_EV_TX]  = tx_load;

  always_comb begin
    awr_d   = awr_q;
    wr_d    = wr_q;
    bv_d    = bv_q;
    bresp_d = bresp_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    arr_d   = arr_q;
    rv_d    = rv_q;
    rd_d    = rd_q;
    rresp_d = rresp_q;
    ctrl_d  = ctrl_q;
    out_d   = out_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    wv      = 32'h0;
    do_wr   = !awr_q && !wr_q && !bv_q;
    if (s_axi_awvalid_in && awr_q) begin
      awr_d = 1'b0;
      awa_d = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wr_q) begin
      wr_d = 1'b0;
      wd_d = s_axi_wdata_in;
      ws_d = s_axi_wstrb_in;
    end
    if (do_wr) begin
      bv_d    = 1'b1;
      bresp_d = mapped(awa_q) ? `RIO_RESP_OKAY : `RIO_RESP_SLVERR;
      if (awa_q == `RIO_ADDR_OUT) begin
        wv    = merge({16'h0, out_q}, wd_q, ws_q);
        out_d = wv[15:0];
      end else if (awa_q == `RIO_ADDR_CTRL) begin
        wv     = merge({30'h0, ctrl_q}, wd_q, ws_q);
        ctrl_d = wv[1:0];
      end else if (awa_q == `RIO_ADDR_STAT) begin
        wv     = merge(32'h0, wd_q, ws_q);
        stat_d = stat_q & ~wv[2:0];
      end else if (awa_q == `RIO_ADDR_MASK) begin
        wv     = merge({29'h0, mask_q}, wd_q, ws_q);
        mask_d = wv[2:0];
      end
    end
    stat_d = stat_d | ev;
    if (bv_q && s_axi_bready_in) begin
      bv_d  = 1'b0;
      awr_d = 1'b1;
      wr_d  = 1'b1;
    end
    if (s_axi_arvalid_in && arr_q) begin
      arr_d   = 1'b0;
      rv_d    = 1'b1;
      rresp_d = mapped(s_axi_araddr_in) ? `RIO_RESP_OKAY : `RIO_RESP_SLVERR;
      if (s_axi_araddr_in == `RIO_ADDR_IN) begin
        rd_d = {16'h0, in_word};
      end else if (s_axi_araddr_in == `RIO_ADDR_OUT) begin
        rd_d = {16'h0, out_q};
      end else if (s_axi_araddr_in == `RIO_ADDR_CTRL) begin
        rd_d = {30'h0, ctrl_q};
      end else if (s_axi_araddr_in == `RIO_ADDR_STAT) begin
        rd_d = {29'h0, stat_q};
      end else if (s_axi_araddr_in == `RIO_ADDR_MASK) begin
        rd_d = {29'h0, mask_q};
      end else if (s_axi_araddr_in == `RIO_ADDR_LINK) begin
        rd_d = {31'h0, err_q};
      end else begin
        rd_d = 32'h0;
      end
    end
    if (rv_q && s_axi_rready_in) begin
      rv_d  = 1'b0;
      arr_d = 1'b1;
    end
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awr_q   <= 1'b1;
      wr_q    <= 1'b1;
      bv_q    <= 1'b0;
      bresp_q <= `RIO_RESP_OKAY;
      awa_q   <= 8'h0;
      wd_q    <= 32'h0;
      ws_q    <= 4'h0;
      arr_q   <= 1'b1;
      rv_q    <= 1'b0;
      rd_q    <= 32'h0;
      rresp_q <= `RIO_RESP_OKAY;
      ctrl_q  <= `RIO_CTRL_RST;
      out_q   <= 16'h0;
      stat_q  <= `RIO_EV_RST;
      mask_q  <= `RIO_EV_RST;
      irq_q   <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      awr_q   <= awr_d;
      wr_q    <= wr_d;
      bv_q    <= bv_d;
      bresp_q <= bresp_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      arr_q   <= arr_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rresp_q <= rresp_d;
      ctrl_q  <= ctrl_d;
      out_q   <= out_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
      fault_q <= err_d;
    end
  end

  // ========================================================================
  // Transmitter to the remote output terminal, no error check on this path
  logic [31:0] per_q, per_d, bt_q, bt_d;
  logic [18:0] tsh_q, tsh_d;
  logic [4:0]  tn_q, tn_d;
  logic        tx_q, tx_d;

  always_comb begin
    per_d   = (per_q == 32'h0) ? 32'(CYCLE_CYC - 1) : per_q - 32'h1;
    tsh_d   = tsh_q;
    tn_d    = tn_q;
    bt_d    = bt_q;
    tx_load = (per_q == 32'h0) && ctrl_q[`RIO_CTRL_TXEN] && (tn_q == 5'h0);
    if (tx_load) begin
      // Fresh word each cycle, so a change held 19.2 ms is sent
      tsh_d = {1'b1, ^out_q, out_q, 1'b0};
      tn_d  = 5'(`RIO_TX_BITS);
      bt_d  = 32'h0;
    end else if (tn_q != 5'h0) begin
      if (bt_q == 32'(BIT_CYC - 1)) begin
        bt_d  = 32'h0;
        tsh_d = {1'b1, tsh_q[18:1]};
        tn_d  = tn_q - 5'h1;
      end else begin
        bt_d = bt_q + 32'h1;
      end
    end
    tx_d = (tn_d != 5'h0) ? tsh_d[0] : 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      per_q <= 32'h0;
      bt_q  <= 32'h0;
      tsh_q <= 19'h7ffff;
      tn_q  <= 5'h0;
      tx_q  <= 1'b1;
    end else begin
      per_q <= per_d;
      bt_q  <= bt_d;
      tsh_q <= tsh_d;
      tn_q  <= tn_d;
      tx_q  <= tx_d;
    end
  end

  assign s_axi_awready_out           = awr_q;
  assign s_axi_wready_out            = wr_q;
  assign s_axi_bvalid_out            = bv_q;
  assign s_axi_bresp_out             = bresp_q;
  assign s_axi_arready_out           = arr_q;
  assign s_axi_rvalid_out            = rv_q;
  assign s_axi_rdata_out             = rd_q;
  assign s_axi_rresp_out             = rresp_q;
  assign serial_line_terminal_tx_out = tx_q;
  assign fault_out                   = fault_q;
  assign irq_out                     = irq_q;

  // ========================================================================
  // Checks
  property p_low_bits;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (rx_c.done && rx_c.ok) |=> (data_q[14:0] == $past(rx_c.data[14:0]));
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("input bits 0 to 14 not taken");

  property p_mode15;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (s_axi_arvalid_in && arr_q && s_axi_araddr_in == `RIO_ADDR_IN &&
     ctrl_q[`RIO_CTRL_MODE15]) |=> (rd_q[15] == $past(err_q));
  endproperty
  a_mode15: assert property (p_mode15)
    else $error("bit 15 not error in upper mode");

  property p_mode16;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (s_axi_arvalid_in && arr_q && s_axi_araddr_in == `RIO_ADDR_IN &&
     !ctrl_q[`RIO_CTRL_MODE15]) |=> (rd_q[15:0] == $past(data_q));
  endproperty
  a_mode16: assert property (p_mode16)
    else $error("input word wrong in lower mode");

  property p_fault;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    rx_c.done |=> ##1 (fault_q == !$past(rx_c.ok, 2));
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not following frame result");

  property p_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (rx_c.done && !rx_c.ok) |=> $stable(data_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data changed on bad frame");

  property p_timeout;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (tmo_q == 32'(TIMEOUT_CYC - 1) && !rx_c.done) |=> err_q && tmo_q == 32'h0;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("missing frame not flagged");

  property p_tx_word;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    tx_load |=> (tsh_q[16:1] == $past(out_q)) && tn_q == 5'(`RIO_TX_BITS)
            ##1 !tx_q;
  endproperty
  a_tx_word: assert property (p_tx_word)
    else $error("output frame not loaded");

  property p_period;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (per_q == 32'h0) |=> (per_q == 32'(CYCLE_CYC - 1));
  endproperty
  a_period: assert property (p_period)
    else $error("cycle period wrong");

  property p_irq;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (|(ev & mask_q)) |=> ##1 (irq_q || ($past(mask_q) != $past(mask_q, 2)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");
endmodule // rio_link_top
`default_nettype wire

// >>> rtl/rio_pkg.sv
// Types shared by the remote I/O link modules.
// Assumes nothing beyond the defines header.
package rio_pkg;
  typedef logic [15:0] rio_word_t;
  typedef enum logic [1:0] {
    RIO_IDLE  = 2'b00,
    RIO_START = 2'b01,
    RIO_DATA  = 2'b11,
    RIO_STOP  = 2'b10
  } rio_line_e;
endpackage

// >>> rtl/rio_rx_frame.sv
// Receiver of one frame from the remote input terminal.
// Assumes the line input is already synchronised to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "rio_defines.svh"
module rio_rx_frame #(
  parameter int unsigned BIT_CYC = `RIO_BIT_CYC
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic line_in,
  rio_rx_if.rx      rx
);
  import rio_pkg::*;

  rio_line_e   st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [4:0]  idx_q, idx_d;
  logic [16:0] sh_q, sh_d;
  logic        done_q, done_d, ok_q, ok_d;
  rio_word_t   data_q, data_d;

  // ========================================================================
  // Frame sequencer
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    idx_d  = idx_q;
    sh_d   = sh_q;
    done_d = 1'b0;
    ok_d   = ok_q;
    data_d = data_q;
    if (cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
    end
    case (st_q)
      RIO_IDLE: begin
        if (!line_in) begin
          st_d  = RIO_START;
          cnt_d = 32'(BIT_CYC / 2);
        end
      end
      RIO_START: begin
        if (cnt_q == 32'h0) begin
          st_d  = line_in ? RIO_IDLE : RIO_DATA;
          // Reload one short: the zero count itself takes a cycle
          cnt_d = 32'(BIT_CYC - 1);
          idx_d = 5'h0;
        end
      end
      RIO_DATA: begin
        if (cnt_q == 32'h0) begin
          sh_d  = {line_in, sh_q[16:1]};
          cnt_d = 32'(BIT_CYC - 1);
          idx_d = idx_q + 5'h1;
          if (idx_q == 5'(`RIO_RX_BITS - 1)) begin
            st_d = RIO_STOP;
          end
        end
      end
      RIO_STOP: begin
        if (cnt_q == 32'h0) begin
          done_d = 1'b1;
          ok_d   = line_in && !(^sh_q);
          data_d = sh_q[15:0];
          st_d   = RIO_IDLE;
        end
      end
      default: st_d = RIO_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q   <= RIO_IDLE;
      cnt_q  <= 32'h0;
      idx_q  <= 5'h0;
      sh_q   <= 17'h0;
      done_q <= 1'b0;
      ok_q   <= 1'b0;
      data_q <= 16'h0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      idx_q  <= idx_d;
      sh_q   <= sh_d;
      done_q <= done_d;
      ok_q   <= ok_d;
      data_q <= data_d;
    end
  end

  assign rx.done = done_q;
  assign rx.ok   = ok_q;
  assign rx.data = data_q;

  // ========================================================================
  // Checks
  property p_parity_stop;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == RIO_STOP && cnt_q == 32'h0) |=>
      done_q && (ok_q == ($past(line_in) && !(^$past(sh_q))));
  endproperty
  a_parity_stop: assert property (p_parity_stop)
    else $error("frame check result wrong");
endmodule // rio_rx_frame
`default_nettype wire

// >>> rtl/rio_rx_if.sv
// Carrier from the frame receiver to the link core.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface rio_rx_if;
  import rio_pkg::*;
  logic      done;
  logic      ok;
  rio_word_t data;
  modport rx   (output done, output ok, output data);
  modport core (input done, input ok, input data);
endinterface
`default_nettype wire
